/* ast_consts.svh */
/*
 * Constants of the serial transceiver: register offsets, field positions,
 * reset values and oversampling counts.
 * Assumes it is included by bare name from each file that needs it.
 */
`ifndef AST_CONSTS_SVH
`define AST_CONSTS_SVH

// ----------------------------------------------------------------------
// Register offsets (word index on the register port)
// ----------------------------------------------------------------------
`define AST_REG_MODE      4'h0
`define AST_REG_STAT      4'h1
`define AST_REG_BRG       4'h2
`define AST_REG_TXDATA    4'h3
`define AST_REG_RXDATA    4'h4

// ----------------------------------------------------------------------
// Mode register fields
// ----------------------------------------------------------------------
`define AST_MODE_ON       15
`define AST_MODE_IDLEHLT  13
`define AST_MODE_IR       12
`define AST_MODE_RTSSTY   11
`define AST_MODE_PINHI    9
`define AST_MODE_PINLO    8
`define AST_MODE_WAKE     7
`define AST_MODE_LOOP     6
`define AST_MODE_AUTO_RATE_MEASURE    5
`define AST_MODE_RXPOL    4
`define AST_MODE_FAST     3
`define AST_MODE_PARHI    2
`define AST_MODE_PARLO    1
`define AST_MODE_STOP2    0
`define AST_MODE_WMASK    16'hbbff
`define AST_MODE_RST      16'h0000

// ----------------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------------
`define AST_STA_TXEN      10
`define AST_STA_TXFULL    9
`define AST_STA_TRMT      8
`define AST_STA_ADDREN    5
`define AST_STA_RIDLE     4
`define AST_STA_PERR      3
`define AST_STA_FERR      2
`define AST_STA_OERR      1
`define AST_STA_AVAIL     0

// ----------------------------------------------------------------------
// Codes, reset values and counts
// ----------------------------------------------------------------------
`define AST_PIN_TXRX      2'h0
`define AST_PIN_RTS       2'h1
`define AST_PIN_RTSCTS    2'h2
`define AST_PIN_BCLK      2'h3
`define AST_PAR_NONE      2'h0
`define AST_PAR_EVEN      2'h1
`define AST_PAR_ODD       2'h2
`define AST_PAR_NINE      2'h3
`define AST_BRG_RST       16'h0000
`define AST_FIFO_DEPTH    4
`define AST_OSR16_LAST    4'hf
`define AST_OSR16_HALF    4'h7
`define AST_OSR4_LAST     4'h3
`define AST_OSR4_HALF     4'h1
`define AST_IR_PULSE      4'h3
`define AST_AB_FALLS      3'h5

`endif

/* ast_pkg.sv */
/*
 * Types shared by the serial transceiver modules.
 * Assumes nothing of its surroundings.
 */
package ast_pkg;
	typedef enum logic [2:0] {
		RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP
	} ast_rx_state_t;
	typedef enum logic [2:0] {
		TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP
	} ast_tx_state_t;
endpackage

/* ast_fifo_if.sv */
/*
 * Carrier between the transceiver and its character queues.
 * Assumes both ends run on the one core clock.
 */
`timescale 1ns/1ps
interface ast_fifo_if #(parameter int unsigned WIDTH = 9);
	logic             push;
	logic             pop;
	logic             flush;
	logic [WIDTH-1:0] wdata;
	logic [WIDTH-1:0] rdata;
	logic             full;
	logic             empty;
	modport ctrl  (output push, pop, flush, wdata, input rdata, full, empty);
	modport store (input push, pop, flush, wdata, output rdata, full, empty);
endinterface

/* ast_fifo.sv */
/*
 * Small first-in first-out character queue.
 * Assumes a power-of-two depth; push when full and pop when empty
 * are ignored.
 */
`timescale 1ns/1ps
module ast_fifo #(
	parameter int unsigned WIDTH = 9,
	parameter int unsigned DEPTH = 4
) (
	input  wire logic   core_clk_i,
	input  wire logic   reset_i,
	ast_fifo_if.store   fifo
);
	localparam int unsigned AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0]    wr_q;
	logic [AW-1:0]    rd_q;
	logic [AW:0]      cnt_q;
	wire              do_push;
	wire              do_pop;

	assign fifo.full  = cnt_q == (AW+1)'(DEPTH);
	assign fifo.empty = cnt_q == '0;
	assign fifo.rdata = mem_q[rd_q];
	assign do_push    = fifo.push && !fifo.full;
	assign do_pop     = fifo.pop && !fifo.empty;

	always_ff @(posedge core_clk_i) begin
		if (do_push) begin
			mem_q[wr_q] <= fifo.wdata;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (reset_i || fifo.flush) begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end else begin
			if (do_push) begin
				wr_q <= wr_q + 1'b1;
			end
			if (do_pop) begin
				rd_q <= rd_q + 1'b1;
			end
			cnt_q <= cnt_q + (AW+1)'(do_push) - (AW+1)'(do_pop);
		end
	end
endmodule

/* ast_uart.sv */
/*
 * Full-duplex asynchronous serial transceiver with baud generator,
 * four-deep queues, error flags, address detect, flow control,
 * infrared codec, loopback, wake on start and rate measurement.
 * Assumes the sleep and idle inputs come from core-clock logic; the
 * serial and clear-to-send pins are asynchronous and synchronised here.
 */
// The strobed register port and the register addresses were decided locally.
// Summary of operation
// (RL1) Full duplex, separate pins, 8/9 data bits
// (RL2) Even/odd/no parity, one or two stops
// (RL3) Bit timing from 16-bit prescaler divisor
// (RL4) Sixteen or four samples per bit
// (RL5) Four-deep transmit queue before shifter
// (RL6) Four-deep receive queue, arrival order
// (RL7) Detect parity, framing and overrun errors
// (RL8) Separate transmit, receive and error events
// (RL9) Nine-bit address detect: ninth bit one
// (RL10) Baud clock output for infrared transceiver
// (RL11) Module enable owns pins; off stops all but wake detect and the wake event
// (RL12) Idle-halt bit stops module in idle
// (RL13) Infrared codec only with sixteen samples
// (RL14) Request pin simplex or flow control
// (RL15) Pin-use field picks the used pins
// (RL16) Wake: falling edge event, rising clears
// (RL17) Loopback returns transmit line to receiver
// (RL18) Measure rate on sync 55h, self-clear
// (RL19) First character after wake may be bad
// (RL20) Fast select: four clocks, else sixteen
// (RL21) Parity/data field encodings
// (RL22) Stop-count bit: two stops when set
// (RL23) Receive polarity bit sets idle level
// (RL24) Start, data LSB first, parity, stops
// (RL25) Flow control gates sending and request
`timescale 1ns/1ps
`include "ast_consts.svh"
module ast_uart #(
	parameter int unsigned FIFO_DEPTH = `AST_FIFO_DEPTH
) (
	input  wire logic        core_clk_i,
	input  wire logic        reset_i,
	input  wire logic [3:0]  reg_addr_i,
	input  wire logic [15:0] reg_wdata_i,
	input  wire logic        reg_wr_i,
	input  wire logic        reg_rd_i,
	output logic [15:0]      reg_rdata_o,
	input  wire logic        idle_mode_i,
	input  wire logic        sleep_mode_i,
	input  wire logic        serial_rx_pin_i,
	input  wire logic        clear_to_send_n_i,
	output logic             serial_tx_pin_o,
	output logic             serial_tx_pin_oe_o,
	output logic             request_to_send_n_o,
	output logic             request_to_send_n_oe_o,
	output logic             baud_clock_out_o,
	output logic             baud_clock_out_oe_o,
	output logic             tx_event_o,
	output logic             rx_event_o,
	output logic             err_event_o,
	output logic             wake_event_o
);
	import ast_pkg::*;

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	logic [1:0]    rx_sync_q, cts_sync_q;
	logic [15:0]   mode_q, brg_q, brg_cnt_q;
	logic          tx_en_q, addr_en_q, oerr_q;
	logic          rx_prev_q, wake_armed_q;
	logic [3:0]    ir_hold_q;
	logic [22:0]   ab_cnt_q;
	logic [2:0]    ab_falls_q;
	ast_rx_state_t rx_st_q;
	logic [3:0]    rx_cnt_q, rx_bit_q;
	logic [8:0]    rx_shift_q;
	logic          rx_perr_q;
	ast_tx_state_t tx_st_q;
	logic [3:0]    tx_cnt_q, tx_bit_q;
	logic [8:0]    tx_shift_q;
	logic          tx_par_q, tx_line_q;

	ast_fifo_if #(.WIDTH(9))  txf ();
	ast_fifo_if #(.WIDTH(11)) rxf ();

	ast_fifo #(.WIDTH(9), .DEPTH(FIFO_DEPTH)) u_tx_fifo ( // [RL5]
		.core_clk_i (core_clk_i),
		.reset_i    (reset_i),
		.fifo       (txf)
	);
	ast_fifo #(.WIDTH(11), .DEPTH(FIFO_DEPTH)) u_rx_fifo ( // [RL6]
		.core_clk_i (core_clk_i),
		.reset_i    (reset_i),
		.fifo       (rxf)
	);

	// ------------------------------------------------------------------
	// Mode decode
	// ------------------------------------------------------------------
	wire       mod_on   = mode_q[`AST_MODE_ON];
	wire       fast     = mode_q[`AST_MODE_FAST];
	wire       loop     = mode_q[`AST_MODE_LOOP];
	wire       ab_on    = mode_q[`AST_MODE_AUTO_RATE_MEASURE];
	wire       wake_on  = mode_q[`AST_MODE_WAKE];
	wire [1:0] pin_use  = mode_q[`AST_MODE_PINHI:`AST_MODE_PINLO];
	wire [1:0] par_sel  = mode_q[`AST_MODE_PARHI:`AST_MODE_PARLO];
	wire       nine     = par_sel == `AST_PAR_NINE;
	wire       has_par  = par_sel == `AST_PAR_EVEN || par_sel == `AST_PAR_ODD;
	wire       odd      = par_sel == `AST_PAR_ODD;
	wire       ir_on    = mode_q[`AST_MODE_IR] && !fast; // [RL13]
	wire [3:0] osr_last = fast ? `AST_OSR4_LAST : `AST_OSR16_LAST; // [RL4] [RL20]
	wire [3:0] osr_half = fast ? `AST_OSR4_HALF : `AST_OSR16_HALF;
	wire [3:0] bit_last = nine ? 4'h8 : 4'h7; // [RL1] [RL21]
	// Idle-halt and sleep freeze the baud ticks; disable resets receiver, transmitter, queues and rate measurement
	wire       run = mod_on && !sleep_mode_i &&
		!(idle_mode_i && mode_q[`AST_MODE_IDLEHLT]); // [RL11] [RL12]

	// ------------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------------
	always_ff @(posedge core_clk_i) begin
		rx_sync_q  <= {rx_sync_q[0], serial_rx_pin_i};
		cts_sync_q <= {cts_sync_q[0], clear_to_send_n_i};
	end

	// ------------------------------------------------------------------
	// Baud generator
	// ------------------------------------------------------------------
	wire tick = run && brg_cnt_q == 16'h0000;
	always_ff @(posedge core_clk_i) begin
		if (reset_i || !run || brg_cnt_q == 16'h0000) begin
			brg_cnt_q <= brg_q; // [RL3]
		end else begin
			brg_cnt_q <= brg_cnt_q - 16'h0001;
		end
	end

	// ------------------------------------------------------------------
	// Receive line: polarity, infrared decode, loopback
	// ------------------------------------------------------------------
	wire rx_raw  = rx_sync_q[1];
	// A short infrared pulse marks a zero bit; stretch it over the bit
	wire ir_line = !(rx_raw || ir_hold_q != 4'h0);
	wire rx_line = loop ? tx_line_q : // [RL17]
		ir_on ? ir_line : rx_raw ^ mode_q[`AST_MODE_RXPOL]; // [RL23]
	wire rx_fall = rx_prev_q && !rx_line;
	wire rx_rise = !rx_prev_q && rx_line;

	always_ff @(posedge core_clk_i) begin
		if (reset_i || !ir_on) begin
			ir_hold_q <= 4'h0;
		end else if (rx_raw) begin
			ir_hold_q <= `AST_OSR16_LAST; // [RL13]
		end else if (tick && ir_hold_q != 4'h0) begin
			ir_hold_q <= ir_hold_q - 4'h1;
		end
	end

	// ------------------------------------------------------------------
	// Wake on start edge and rate measurement
	// ------------------------------------------------------------------
	wire wake_fall  = sleep_mode_i && wake_on && rx_fall; // [RL16]
	wire wake_clr   = wake_armed_q && rx_rise; // [RL16]
	wire ab_busy    = ab_on && rx_st_q == RX_IDLE; // [RL18]
	wire ab_done    = ab_busy && rx_fall && ab_falls_q == `AST_AB_FALLS - 3'h1;
	// Sync 55h gives five falling edges spanning eight bit times
	wire [15:0] ab_meas = fast ? ab_cnt_q[20:5] : ab_cnt_q[22:7];
	wire [15:0] ab_brg  = ab_meas == 16'h0000 ? 16'h0000 : ab_meas - 16'h0001;

	always_ff @(posedge core_clk_i) begin
		if (reset_i || !mod_on || !ab_busy) begin
			ab_cnt_q   <= '0;
			ab_falls_q <= 3'h0;
		end else begin
			if (ab_falls_q != 3'h0) begin
				ab_cnt_q <= ab_cnt_q + 23'h1;
			end
			if (rx_fall) begin
				ab_falls_q <= ab_falls_q + 3'h1;
			end
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			rx_prev_q    <= 1'b1;
			wake_armed_q <= 1'b0;
		end else begin
			rx_prev_q    <= rx_line;
			wake_armed_q <= wake_clr ? 1'b0 : (wake_armed_q || wake_fall);
		end
	end

	// ------------------------------------------------------------------
	// Receiver
	// ------------------------------------------------------------------
	wire       rx_samp = tick && rx_cnt_q == osr_last;
	wire [8:0] rx_word = nine ? rx_shift_q : {1'b0, rx_shift_q[8:1]};
	wire       rx_pexp = ^rx_word[7:0] ^ odd;
	wire       rx_end  = rx_st_q == RX_STOP && rx_samp;
	wire       rx_drop = addr_en_q && nine && !rx_word[8]; // [RL9]
	wire       rx_ovr  = rx_end && !rx_drop && rxf.full; // [RL7]
	wire       rx_ferr = !rx_line; // [RL7]

	always_ff @(posedge core_clk_i) begin
		if (reset_i || !mod_on) begin
			rx_st_q <= RX_IDLE;
			rx_cnt_q <= 4'h0;
			rx_bit_q <= 4'h0;
			rx_shift_q <= 9'h000;
			rx_perr_q <= 1'b0;
		end else begin
			if (tick) begin
				rx_cnt_q <= rx_samp ? 4'h0 : rx_cnt_q + 4'h1;
			end
			case (rx_st_q)
				RX_IDLE: begin
					rx_cnt_q <= 4'h0;
					rx_perr_q <= 1'b0;
					// Start on an edge: a low stop bit is no new start
					if (run && !ab_on && rx_fall) begin
						rx_st_q <= RX_START; // [RL24]
					end
				end
				RX_START: begin
					if (tick && rx_cnt_q == osr_half) begin
						rx_cnt_q <= 4'h0;
						rx_bit_q <= 4'h0;
						rx_st_q <= rx_line ? RX_IDLE : RX_DATA;
					end
				end
				RX_DATA: begin
					if (rx_samp) begin
						rx_shift_q <= {rx_line, rx_shift_q[8:1]}; // [RL24]
						rx_bit_q <= rx_bit_q + 4'h1;
						if (rx_bit_q == bit_last) begin
							rx_st_q <= has_par ? RX_PAR : RX_STOP;
						end
					end
				end
				RX_PAR: begin
					if (rx_samp) begin
						rx_perr_q <= rx_line != rx_pexp; // [RL2] [RL7]
						rx_st_q <= RX_STOP;
					end
				end
				RX_STOP: begin
					if (rx_samp) begin
						rx_st_q <= RX_IDLE;
					end
				end
				default: rx_st_q <= RX_IDLE;
			endcase
		end
	end

	wire rx_read = reg_rd_i && reg_addr_i == `AST_REG_RXDATA;
	wire oerr_clr = reg_wr_i && reg_addr_i == `AST_REG_STAT && oerr_q &&
		!reg_wdata_i[`AST_STA_OERR];
	assign rxf.push  = rx_end && !rx_drop && !rxf.full;
	assign rxf.wdata = {rx_ferr, rx_perr_q, rx_word};
	assign rxf.pop   = rx_read;
	assign rxf.flush = !mod_on || oerr_clr;

	// ------------------------------------------------------------------
	// Transmitter
	// ------------------------------------------------------------------
	wire cts_ok  = pin_use != `AST_PIN_RTSCTS || !cts_sync_q[1]; // [RL25]
	wire tx_go   = tx_st_q == TX_IDLE && run && tx_en_q && !txf.empty &&
		cts_ok;
	wire tx_bend = tick && tx_cnt_q == osr_last;

	always_ff @(posedge core_clk_i) begin
		if (reset_i || !mod_on || !tx_en_q) begin
			tx_st_q <= TX_IDLE;
			tx_cnt_q <= 4'h0;
			tx_bit_q <= 4'h0;
			tx_shift_q <= 9'h000;
			tx_par_q <= 1'b0;
			tx_line_q <= 1'b1;
		end else begin
			if (tick) begin
				tx_cnt_q <= tx_bend ? 4'h0 : tx_cnt_q + 4'h1;
			end
			case (tx_st_q)
				TX_IDLE: begin
					tx_cnt_q <= 4'h0;
					tx_bit_q <= 4'h0;
					if (tx_go) begin
						tx_shift_q <= txf.rdata;
						tx_par_q <= ^txf.rdata[7:0] ^ odd; // [RL2]
						tx_line_q <= 1'b0; // [RL24]
						tx_st_q <= TX_START;
					end
				end
				TX_START: begin
					if (tx_bend) begin
						tx_line_q <= tx_shift_q[0];
						tx_st_q <= TX_DATA;
					end
				end
				TX_DATA: begin
					if (tx_bend) begin
						tx_shift_q <= {1'b0, tx_shift_q[8:1]};
						tx_bit_q <= tx_bit_q + 4'h1;
						tx_line_q <= tx_shift_q[1]; // [RL24]
						if (tx_bit_q == bit_last) begin
							tx_bit_q <= 4'h0;
							tx_line_q <= has_par ? tx_par_q : 1'b1;
							tx_st_q <= has_par ? TX_PAR : TX_STOP;
						end
					end
				end
				TX_PAR: begin
					if (tx_bend) begin
						tx_line_q <= 1'b1;
						tx_st_q <= TX_STOP;
					end
				end
				TX_STOP: begin
					if (tx_bend) begin
						tx_bit_q <= 4'h1;
						// Second stop bit only when selected
						if (!mode_q[`AST_MODE_STOP2] || tx_bit_q != 4'h0) begin
							tx_st_q <= TX_IDLE; // [RL22]
						end
					end
				end
				default: tx_st_q <= TX_IDLE;
			endcase
		end
	end

	wire tx_write = reg_wr_i && reg_addr_i == `AST_REG_TXDATA;
	assign txf.push  = tx_write;
	assign txf.wdata = reg_wdata_i[8:0];
	assign txf.pop   = tx_go;
	assign txf.flush = !mod_on || !tx_en_q;

	// ------------------------------------------------------------------
	// Pin drive
	// ------------------------------------------------------------------
	wire ir_pulse = !tx_line_q && tx_st_q != TX_IDLE &&
		tx_cnt_q < `AST_IR_PULSE;
	// Loopback holds the pin high, the idle level except in infrared mode, so the far node sees no frame
	wire tx_pin_d = loop ? 1'b1 :
		ir_on ? ir_pulse : tx_line_q; // [RL13] [RL17]
	wire rts_used = pin_use == `AST_PIN_RTS || pin_use == `AST_PIN_RTSCTS;
	wire rts_d = mode_q[`AST_MODE_RTSSTY] ? tx_st_q == TX_IDLE :
		rxf.full; // [RL14] [RL25]
	wire bclk_d = brg_cnt_q > {1'b0, brg_q[15:1]}; // [RL10]

	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			serial_tx_pin_o        <= 1'b1;
			serial_tx_pin_oe_o     <= 1'b0;
			request_to_send_n_o    <= 1'b1;
			request_to_send_n_oe_o <= 1'b0;
			baud_clock_out_o       <= 1'b0;
			baud_clock_out_oe_o    <= 1'b0;
		end else begin
			serial_tx_pin_o        <= tx_pin_d;
			serial_tx_pin_oe_o     <= mod_on && tx_en_q; // [RL11] [RL15]
			request_to_send_n_o    <= rts_d;
			request_to_send_n_oe_o <= mod_on && rts_used; // [RL15]
			baud_clock_out_o       <= run && bclk_d;
			baud_clock_out_oe_o    <= mod_on && pin_use == `AST_PIN_BCLK;
		end
	end

	// ------------------------------------------------------------------
	// Registers and events
	// ------------------------------------------------------------------
	wire wr_mode = reg_wr_i && reg_addr_i == `AST_REG_MODE;
	wire wr_stat = reg_wr_i && reg_addr_i == `AST_REG_STAT;
	wire wr_brg  = reg_wr_i && reg_addr_i == `AST_REG_BRG;
	wire [15:0] stat_v = {5'h00, tx_en_q, txf.full,
		txf.empty && tx_st_q == TX_IDLE, 2'h0, addr_en_q,
		rx_st_q == RX_IDLE, rxf.rdata[9] && !rxf.empty,
		rxf.rdata[10] && !rxf.empty, oerr_q, !rxf.empty};
	wire [15:0] rd_mux =
		reg_addr_i == `AST_REG_MODE   ? mode_q :
		reg_addr_i == `AST_REG_STAT   ? stat_v :
		reg_addr_i == `AST_REG_BRG    ? brg_q :
		reg_addr_i == `AST_REG_RXDATA ? {7'h00, rxf.rdata[8:0]} : 16'h0000;

	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			mode_q    <= `AST_MODE_RST;
			brg_q     <= `AST_BRG_RST;
			tx_en_q   <= 1'b0;
			addr_en_q <= 1'b0;
		end else begin
			if (wr_mode) begin
				mode_q <= reg_wdata_i & `AST_MODE_WMASK;
			end else begin
				if (wake_clr) begin
					mode_q[`AST_MODE_WAKE] <= 1'b0; // [RL16]
				end
				if (ab_done) begin
					mode_q[`AST_MODE_AUTO_RATE_MEASURE] <= 1'b0; // [RL18]
				end
			end
			if (wr_brg) begin
				brg_q <= reg_wdata_i;
			end else if (ab_done) begin
				brg_q <= ab_brg; // [RL18]
			end
			if (wr_stat) begin
				tx_en_q   <= reg_wdata_i[`AST_STA_TXEN];
				addr_en_q <= reg_wdata_i[`AST_STA_ADDREN];
			end
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			oerr_q       <= 1'b0;
			reg_rdata_o  <= 16'h0000;
			tx_event_o   <= 1'b0;
			rx_event_o   <= 1'b0;
			err_event_o  <= 1'b0;
			wake_event_o <= 1'b0;
		end else begin
			oerr_q       <= rx_ovr || (oerr_q && !oerr_clr); // [RL7]
			reg_rdata_o  <= reg_rd_i ? rd_mux : 16'h0000;
			tx_event_o   <= tx_go; // [RL8]
			rx_event_o   <= rxf.push; // [RL8]
			err_event_o  <= rx_ovr || (rxf.push &&
				(rx_ferr || rx_perr_q)); // [RL8]
			wake_event_o <= wake_fall; // [RL16] [RL19]
		end
	end
endmodule

/* ast_node.sv */
/* Remote serial node that drives the transceiver receive line.
   Drives the line high itself between frames; needs no pull-up. */
`timescale 1ns/1ps
module ast_node (
	input  wire logic clk_i,
	output logic      line_o
);
	initial line_o = 1'b1;
	// Start low, data LSB first, then parity and stop tail
	task automatic send(input logic [8:0] d, input int nd,
		input logic [2:0] tl, input int nt, input int bl);
		logic [12:0] f;
		f = (13'(d) << 1) | (13'(tl) << (nd + 1));
		for (int i = 0; i < nd + nt + 1; i++) begin
			@(posedge clk_i);
			line_o <= f[i];
			repeat (bl - 1) @(posedge clk_i);
		end
		@(posedge clk_i);
		line_o <= 1'b1;
	endtask
endmodule

/* ast_uart_sva.sv */
/* Checker bound to the transceiver top.
   Assumes the register map of ast_consts.svh. */
`timescale 1ns/1ps
`include "ast_consts.svh"
module ast_uart_sva #(
	parameter int unsigned FIFO_DEPTH = 4
) (
	input wire logic        core_clk_i,
	input wire logic        reset_i,
	input wire logic [3:0]  reg_addr_i,
	input wire logic [15:0] reg_wdata_i,
	input wire logic        reg_wr_i,
	input wire logic        sleep_mode_i,
	input wire logic        serial_tx_pin_o,
	input wire logic        serial_tx_pin_oe_o,
	input wire logic        request_to_send_n_o,
	input wire logic        request_to_send_n_oe_o,
	input wire logic        baud_clock_out_oe_o,
	input wire logic        tx_event_o,
	input wire logic        rx_event_o,
	input wire logic        wake_event_o
);
	logic [15:0] mode_q;
	logic        txen_q;
	logic [1:0]  quiet_q;
	wire         mode_wr = reg_wr_i && reg_addr_i == `AST_REG_MODE;
	wire         stat_wr = reg_wr_i && reg_addr_i == `AST_REG_STAT;
	wire         on      = mode_q[`AST_MODE_ON];
	wire [1:0]   pins    = mode_q[`AST_MODE_PINHI:`AST_MODE_PINLO];
	// Outputs are registered: judge them only a few cycles after a write
	wire         settled = quiet_q == 2'h3;
	wire         plain   = !mode_q[`AST_MODE_IR] && !mode_q[`AST_MODE_LOOP];
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			mode_q  <= 16'h0000;
			txen_q  <= 1'b0;
			quiet_q <= 2'h0;
		end else begin
			if (mode_wr)
				mode_q <= reg_wdata_i;
			if (stat_wr)
				txen_q <= reg_wdata_i[`AST_STA_TXEN];
			if (mode_wr || stat_wr)
				quiet_q <= 2'h0;
			else if (!settled)
				quiet_q <= quiet_q + 2'h1;
		end
	end
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (reset_i);
	txpin_own_a: assert property (settled |->
		serial_tx_pin_oe_o == (on && txen_q)) else $error("tx enable");
	bclk_own_a: assert property (settled |->
		baud_clock_out_oe_o == (on && pins == 2'h3)) else $error("bclk oe");
	rts_own_a: assert property (settled |-> request_to_send_n_oe_o ==
		(on && (pins == 2'h1 || pins == 2'h2))) else $error("rts oe");
	off_quiet_a: assert property (settled && !on |->
		!tx_event_o && !rx_event_o) else $error("event while off");
	start_low_a: assert property (tx_event_o && settled && plain |->
		##[1:2] !serial_tx_pin_o) else $error("no start bit");
	loop_hold_a: assert property (settled && on && mode_q[`AST_MODE_LOOP]
		|-> serial_tx_pin_o) else $error("tx pin moves in loopback");
	wake_sleep_a: assert property (wake_event_o |->
		sleep_mode_i || $past(sleep_mode_i)) else $error("wake awake");
	reset_pins_a: assert property (disable iff (1'b0) reset_i |=>
		serial_tx_pin_o && !serial_tx_pin_oe_o && request_to_send_n_o)
		else $error("pins after reset");
	cover property (tx_event_o);
	cover property (rx_event_o);
	cover property (wake_event_o);
endmodule
bind ast_uart ast_uart_sva #(.FIFO_DEPTH(FIFO_DEPTH)) sva_i (
	.core_clk_i, .reset_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
	.sleep_mode_i, .serial_tx_pin_o, .serial_tx_pin_oe_o,
	.request_to_send_n_o, .request_to_send_n_oe_o, .baud_clock_out_oe_o,
	.tx_event_o, .rx_event_o, .wake_event_o
);

/* tb.sv */
/* Self-checking bench for the serial transceiver.
   Assumes the remote node model and the bound checker. */
`timescale 1ns/1ps
`include "ast_consts.svh"
module tb;
	logic        core_clk_i;
	logic        reset_i;
	logic [3:0]  reg_addr_i;
	logic [15:0] reg_wdata_i;
	logic        reg_wr_i;
	logic        reg_rd_i;
	logic [15:0] reg_rdata_o;
	logic        idle_mode_i;
	logic        sleep_mode_i;
	logic        serial_rx_pin_i;
	logic        clear_to_send_n_i;
	logic        serial_tx_pin_o;
	logic        request_to_send_n_oe_o;
	logic        baud_clock_out_oe_o;
	logic        tx_event_o;
	logic        rx_event_o;
	logic        wake_event_o;
	wire [1:0]   oes = {request_to_send_n_oe_o, baud_clock_out_oe_o};
	int          fails;
	int          n_compared;
	int          wakes;
	ast_uart dut (
		.core_clk_i, .reset_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
		.reg_rd_i, .reg_rdata_o, .idle_mode_i, .sleep_mode_i,
		.serial_rx_pin_i, .clear_to_send_n_i, .serial_tx_pin_o,
		.serial_tx_pin_oe_o(), .request_to_send_n_o(),
		.request_to_send_n_oe_o, .baud_clock_out_o(), .baud_clock_out_oe_o,
		.tx_event_o, .rx_event_o, .err_event_o(), .wake_event_o
	);
	ast_node node (
		.clk_i (core_clk_i),
		.line_o(serial_rx_pin_i)
	);
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("wrong value at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge core_clk_i);
		reg_addr_i  <= a;
		reg_wdata_i <= d;
		reg_wr_i    <= 1'b1;
		@(posedge core_clk_i);
		reg_wr_i <= 1'b0;
	endtask
	task automatic rc(input logic [3:0] a, input logic [15:0] e,
		input logic [15:0] m = 16'hffff);
		@(posedge core_clk_i);
		reg_addr_i <= a;
		reg_rd_i   <= 1'b1;
		@(posedge core_clk_i);
		reg_rd_i <= 1'b0;
		#1 chk(reg_rdata_o & m, e);
	endtask
	// Sends one character and checks every bit on the line mid-bit
	task automatic txchk(input logic [1:0] p, input logic s);
		logic [12:0] f;
		logic [8:0]  d;
		int          n;
		d = 9'h1b5;
		n = (p == `AST_PAR_NINE) ? 9 : 8;
		f = '1;
		f[0] = 1'b0;
		for (int i = 0; i < n; i++)
			f[i + 1] = d[i];
		if (p == `AST_PAR_EVEN)
			f[n + 1] = ^d[7:0];
		if (p == `AST_PAR_ODD)
			f[n + 1] = ~^d[7:0];
		n = n + 2 + int'(s) + int'(p == `AST_PAR_EVEN || p == `AST_PAR_ODD);
		wr(`AST_REG_MODE, {13'h1001, p, s});
		wr(`AST_REG_TXDATA, {7'h00, d});
		for (int k = 0; k < 200 && serial_tx_pin_o !== 1'b0; k++)
			@(posedge core_clk_i);
		repeat (4) @(posedge core_clk_i);
		for (int i = 0; i < n; i++) begin
			#1 chk(16'(serial_tx_pin_o), 16'(f[i]));
			repeat (8) @(posedge core_clk_i);
		end
	endtask
	task automatic close_out;
		$display("compared %0d, mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		core_clk_i = 1'b0;
		forever #10 core_clk_i = ~core_clk_i;
	end
	always @(posedge core_clk_i)
		if (wake_event_o === 1'b1)
			wakes++;
	// Whole run needs well under this many cycles
	initial begin
		repeat (30000) @(posedge core_clk_i);
		fails++;
		close_out();
	end
	// --------------------
	// Test sequence
	// --------------------
	initial begin
		logic [15:0] e;
		reset_i = 1'b1;
		{reg_addr_i, reg_wdata_i, reg_wr_i, reg_rd_i} = '0;
		{idle_mode_i, sleep_mode_i, clear_to_send_n_i} = 3'h0;
		repeat (6) @(posedge core_clk_i);
		reset_i <= 1'b0;
		rc(`AST_REG_MODE, 16'h0000);
		rc(`AST_REG_STAT, 16'h0110);
		rc(4'hf, 16'h0000);
		wr(`AST_REG_MODE, 16'hffff);
		rc(`AST_REG_MODE, `AST_MODE_WMASK);
		wr(`AST_REG_BRG, 16'h0001);
		rc(`AST_REG_BRG, 16'h0001);
		$display("registers done");
		wr(`AST_REG_STAT, 16'h0400);
		for (int p = 0; p < 4; p++)
			txchk(2'(p), p[1]);
		$display("transmit formats done");
		for (int u = 0; u < 4; u++) begin
			wr(`AST_REG_MODE, 16'h8008 | 16'(u << 8));
			repeat (4) @(posedge core_clk_i);
			e = (u == 0) ? 16'h0 : (u == 3) ? 16'h1 : 16'h2;
			chk(16'(oes), e);
		end
		$display("pin use done");
		wr(`AST_REG_MODE, 16'h8008);
		node.send(9'h031, 8, 3'h1, 1, 8);
		node.send(9'h0c2, 8, 3'h1, 1, 8);
		repeat (4) @(posedge core_clk_i);
		rc(`AST_REG_RXDATA, 16'h0031);
		rc(`AST_REG_RXDATA, 16'h00c2);
		wr(`AST_REG_MODE, 16'h800a);
		node.send(9'h003, 8, 3'h3, 2, 8);
		repeat (4) @(posedge core_clk_i);
		rc(`AST_REG_STAT, 16'h0009, 16'h000f);
		rc(`AST_REG_RXDATA, 16'h0003);
		wr(`AST_REG_MODE, 16'h8008);
		node.send(9'h044, 8, 3'h0, 1, 8);
		repeat (4) @(posedge core_clk_i);
		rc(`AST_REG_STAT, 16'h0005, 16'h000f);
		rc(`AST_REG_RXDATA, 16'h0044);
		for (int i = 0; i < 5; i++)
			node.send(9'(i + 16), 8, 3'h1, 1, 8);
		repeat (4) @(posedge core_clk_i);
		rc(`AST_REG_STAT, 16'h0003, 16'h0003);
		for (int i = 0; i < 4; i++)
			rc(`AST_REG_RXDATA, 16'(i + 16));
		wr(`AST_REG_STAT, 16'h0400);
		$display("receive done");
		wr(`AST_REG_MODE, 16'h8048);
		wr(`AST_REG_TXDATA, 16'h005a);
		for (int k = 0; k < 300 && rx_event_o !== 1'b1; k++)
			@(posedge core_clk_i);
		rc(`AST_REG_RXDATA, 16'h005a);
		$display("loopback done");
		wr(`AST_REG_BRG, 16'h0000);
		wr(`AST_REG_MODE, 16'h8028);
		node.send(9'h055, 8, 3'h1, 1, 10);
		repeat (4) @(posedge core_clk_i);
		rc(`AST_REG_MODE, 16'h8008);
		rc(`AST_REG_BRG, 16'h0001);
		$display("rate measure done");
		wr(`AST_REG_MODE, 16'h8088);
		sleep_mode_i <= 1'b1;
		node.send(9'h000, 8, 3'h1, 1, 8);
		sleep_mode_i <= 1'b0;
		chk(16'(wakes), 16'h0001);
		rc(`AST_REG_MODE, 16'h8008);
		$display("wake done");
		close_out();
	end
endmodule
